// *** dv/adcs_host_model.sv ***
// Serial host model driving select, clock and data pins
`timescale 1ns/1ps
module adcs_host_model
(
   input  wire logic clock_in,
   input  wire logic dout_in,
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic      din_out
);
   initial
   begin
      cs_n_out = 1'h1;
      sclk_out = 1'h0;
      din_out  = 1'h0;
   end
   task automatic sel(input logic v);
      @(negedge clock_in);
      cs_n_out = v;
      // Released data line shows the inverse of its last value
      if (v)
         din_out = ~din_out;
      repeat (10) @(negedge clock_in);
   endtask
   // Bytes go out first bit first, clock unbroken
   task automatic xfer(input logic [7:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      for (int k = 0; k < n; k++)
      begin
         din_out = tx[7];
         tx = tx << 1;
         repeat (10) @(negedge clock_in);
         rx[15 - k] = dout_in;
         sclk_out = 1'h1;
         repeat (10) @(negedge clock_in);
         sclk_out = 1'h0;
      end
   endtask
endmodule // adcs_host_model

// *** dv/tb.sv ***
// Self-checking bench of the serial conversion sequencer
`timescale 1ns/1ps
module tb;
   logic                clock_in = 1'h0;
   logic                rst_n_in = 1'h0;
   logic [7:0]          sample_code_in = 8'h00;
   wire logic           cs_n, sclk, din, dout, dout_oe, track, conv;
   wire logic           ref_sel, ref_on, chip_on, waking;
   adcs_pkg::adcs_mux_t mux;
   logic [15:0]         r;
   int                  bad_count = 0;
   int                  total_checks = 0;
   logic [4:0]          mx [0:7] = '{5'h12, 5'h05, 5'h09, 5'h01, 5'h0a, 5'h02, 5'h08, 5'h00};
   always #2 clock_in = ~clock_in;
   adcs_host_model host (.clock_in(clock_in), .dout_in(dout), .cs_n_out(cs_n),
      .sclk_out(sclk), .din_out(din));
   adcs_sequencer #(.WAKE_CYCLES(20)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din), .sample_code_in(sample_code_in),
      .dout_out(dout), .dout_oe_out(dout_oe), .track_out(track), .converting_out(conv),
      .mux_out(mux), .reference_source_select_out(ref_sel),
      .reference_power_on_out(ref_on), .chip_power_on_out(chip_on), .waking_out(waking));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_ext();
      for (int s = 0; s < 8; s++)
      begin
         sample_code_in = 8'h3c ^ 8'(s * 37);
         host.sel(1'h0);
         host.xfer({1'h1, 3'(s), 4'hb}, 16, r);
         chk(r, {8'h00, sample_code_in});
         chk({11'h0, mux}, {11'h0, mx[s]});
         host.xfer(8'h00, 2, r);
         chk(r, 16'h0000);
         host.sel(1'h1);
         chk({15'h0, dout_oe}, 16'h0000);
      end
      $display("Test external readout done");
   endtask
   task automatic t_int();
      sample_code_in = 8'hc3;
      host.sel(1'h0);
      host.xfer(8'hf3, 8, r);
      repeat (6) @(negedge clock_in);
      chk({14'h0, track, conv}, 16'h0001);
      host.sel(1'h1);
      chk({15'h0, conv}, 16'h0001);
      for (int i = 0; i < 8750 && conv; i++)
         @(negedge clock_in);
      chk({15'h0, conv}, 16'h0000);
      host.sel(1'h0);
      host.xfer(8'h00, 8, r);
      chk(r, {8'hc3, 8'h00});
      host.sel(1'h1);
      $display("Test internal conversion done");
   endtask
   task automatic t_pd();
      sample_code_in = 8'h81;
      host.sel(1'h0);
      host.xfer(8'hf8, 8, r);
      chk({15'h0, chip_on}, 16'h0001);
      host.xfer(8'h00, 8, r);
      repeat (6) @(negedge clock_in);
      chk({15'h0, chip_on}, 16'h0000);
      host.sel(1'h1);
      host.sel(1'h0);
      host.xfer(8'h00, 2, r);
      chk({15'h0, waking}, 16'h0000);
      host.xfer(8'h80, 1, r);
      chk({15'h0, waking}, 16'h0001);
      host.xfer(8'hf6, 7, r);
      host.xfer(8'h00, 9, r);
      chk(r, {8'h81, 8'h00});
      chk({15'h0, chip_on}, 16'h0001);
      host.sel(1'h1);
      $display("Test power-down and wake done");
   endtask
   task automatic t_stream();
      sample_code_in = 8'h5a;
      host.sel(1'h0);
      // Input held high: all-ones bytes every ten clocks
      host.xfer(8'hff, 8, r);
      host.xfer(8'hff, 8, r);
      chk(r, {8'h5a, 8'h00});
      sample_code_in = 8'ha5;
      host.xfer(8'hff, 2, r);
      chk(r, 16'h0000);
      host.xfer(8'hff, 8, r);
      chk(r, {8'ha5, 8'h00});
      chk({11'h0, mux}, 16'h0000);
      chk({14'h0, ref_sel, ref_on}, 16'h0003);
      host.sel(1'h1);
      chk({15'h0, conv}, 16'h0000);
      sample_code_in = 8'h69;
      host.sel(1'h0);
      // Fresh frame 8'hfb after the abort, reference select bit clear
      host.xfer(8'hfb, 8, r);
      host.xfer(8'h00, 8, r);
      chk(r, {8'h69, 8'h00});
      host.sel(1'h1);
      $display("Test stream and abort done");
   endtask
   initial
   begin
      repeat (4) @(negedge clock_in);
      rst_n_in = 1'h1;
      // Settle wait before the first byte
      repeat (10) @(negedge clock_in);
      chk({13'h0, ref_on, chip_on, dout_oe}, 16'h0002);
      t_ext();
      t_int();
      t_pd();
      t_stream();
      report_and_stop();
   end
   initial
   begin
      #200000;
      bad_count++;
      report_and_stop();
   end
endmodule // tb

// *** rtl/adcs_pair_fifo.sv ***
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module adcs_pair_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
)
(
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    cnt_ff;
   logic             push;
   logic             pop;

   assign in_ready_out  = (cnt_ff != CW'(DEPTH));
   assign out_valid_out = (cnt_ff != '0);
   assign out_data_out  = mem_ff[rd_ptr_ff];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always_ff @(posedge clock_in)
   begin
      if (push)
         mem_ff[wr_ptr_ff] <= in_data_in;
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
         if (pop)
            rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
         if (push && !pop)
            cnt_ff <= cnt_ff + 1'b1;
         else if (pop && !push)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end

   a_fifo_bound: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      cnt_ff <= CW'(DEPTH)) else $error("Buffer count overflow");

endmodule // adcs_pair_fifo

// *** rtl/adcs_pkg.sv ***
// Shared constants and types for the serial conversion sequencer
package adcs_pkg;

   // Clock and timing
   localparam int CLK_KHZ        = 250_000;
   localparam int OSC_KHZ        = 400;
   localparam int OSC_DIV        = CLK_KHZ / OSC_KHZ;
   localparam int CONV_MAX_NS    = 35_000;
   localparam int CONV_MAX_CYC   = CONV_MAX_NS * (CLK_KHZ / 1000) / 1000;
   localparam int CONV_TICKS     = 8;
   localparam int WAKE_NS        = 20_000;
   localparam int WAKE_CYC       = WAKE_NS * (CLK_KHZ / 1000) / 1000;

   // Serial clock edge numbers, counted from the start bit
   localparam logic [3:0] EDGE_TRACK    = 4'h4;
   localparam logic [3:0] EDGE_EXT_CONV = 4'h6;
   localparam logic [3:0] EDGE_EXT_MSB  = 4'h7;
   localparam logic [3:0] EDGE_CTRL     = 4'h8;
   localparam logic [3:0] EDGE_OVL_EXT  = 4'ha;
   localparam logic [3:0] EDGE_EXT_DONE = 4'hf;
   localparam logic [3:0] EDGE_CLKSEL   = 4'h5;
   localparam logic [3:0] EDGE_SEL      = 4'h4;

   // Readout bit index: 1 is the top bit, idle shows zeros
   localparam logic [3:0] RD_FIRST   = 4'h1;
   localparam logic [3:0] RD_OVL_EXT = 4'h3;
   localparam logic [3:0] RD_OVL_INT = 4'h4;
   localparam logic [3:0] RD_IDLE    = 4'h9;

   // Reset values
   localparam logic [2:0] SYNC_RST      = 3'h4;
   localparam logic       CHIP_ON_RST   = 1'h1;
   localparam logic       REF_ON_RST    = 1'h0;
   localparam logic [7:0] CTRL_RST      = 8'h00;

   // Input multiplexer codes
   localparam logic [1:0] POS_A    = 2'h0;
   localparam logic [1:0] POS_B    = 2'h1;
   localparam logic [1:0] POS_HALF = 2'h2;
   localparam logic [1:0] NEG_COM  = 2'h0;
   localparam logic [1:0] NEG_GND  = 2'h1;
   localparam logic [1:0] NEG_B    = 2'h2;

   typedef struct packed {
      logic       start;
      logic [2:0] input_select;
      logic       conv_clock_select;
      logic       reference_source_select;
      logic       reference_power_on;
      logic       chip_power_on;
   } adcs_ctrl_t;

   typedef struct packed {
      logic [1:0] pos_sel;
      logic [1:0] neg_sel;
      logic       bipolar;
   } adcs_mux_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FRAME = 3'b010,
      ST_ICONV = 3'b100
   } adcs_state_t;

endpackage

// *** rtl/adcs_sequencer.sv ***
// Serial control and conversion sequencer of the two-channel converter
`timescale 1ns/1ps
// Summary of operation
// - Decode select field into positive input, negative input and polarity.
// - External clock: top bit decided rise 7, shifted out falls 8 to 15.
// - After last bit send zeros until select rises, then tri-state.
// - Internal clock: track at fall 4, conversion starts at fall 8.
// - Internal conversion on 400 kHz ticks, under 35 us, top bit shown.
// - Select high: input ignored, output off, internal conversion continues.
// - Select low, input high: repeated all-ones bytes, ten clocks each.
// - Select falling alone starts nothing; first high bit is start bit.
// - Acquisition from fall 4 lasting two or four clocks, then conversion.
// - Idle converter accepts a high bit with select low as start.
// - External mode: after bit 5 shown, next high bit starts again.
// - Internal mode: after bit 4 shown, next high bit starts again.
// - Back-to-back external conversions every ten serial clocks.
// - External mode: select toggle mid-conversion abandons the conversion.
// - Power-up: reference off, chip not shut down, waiting for a byte.
// - Power-down request acts only after its conversion has finished.
// - Reference bit 0 turns reference off; chip bit 0 powers down.
// - Input sampled on rising edges; zeros before start bit ignored.
// - External: output low on select fall, track fall 4, convert fall 6.
// - Start bit wakes chip in 20 us; reference only if internal before.
module adcs_sequencer
#(
   parameter int WAKE_CYCLES = adcs_pkg::WAKE_CYC
)
(
   input  wire logic              clock_in,
   input  wire logic              rst_n_in,
   input  wire logic              cs_n_in,
   input  wire logic              sclk_in,
   input  wire logic              din_in,
   input  wire logic [7:0]        sample_code_in,
   output logic                   dout_out,
   output logic                   dout_oe_out,
   output logic                   track_out,
   output logic                   converting_out,
   output adcs_pkg::adcs_mux_t    mux_out,
   output logic                   reference_source_select_out,
   output logic                   reference_power_on_out,
   output logic                   chip_power_on_out,
   output logic                   waking_out
);

   logic [1:0]            rst_sync_ff;
   logic                  rst_s;
   logic [2:0]            pin_s1_ff;
   logic [2:0]            pin_s2_ff;
   logic                  sclk_d_ff;
   logic                  cs_d_ff;
   logic                  cs_s;
   logic                  din_s;
   logic                  rise;
   logic                  fall;
   logic                  cs_rise;
   adcs_pkg::adcs_state_t state_ff;
   logic [3:0]            fcnt_ff;
   logic [7:0]            shift_ff;
   logic                  ext_ff;
   adcs_pkg::adcs_ctrl_t  ctrl_ff;
   logic                  allow_start;
   logic                  start_ev;
   logic                  fr_rise;
   logic                  fr_fall;
   logic                  ext_end;
   logic                  conv_end;
   logic                  abort_ev;
   logic [9:0]            osc_ff;
   logic                  osc_tick;
   logic [3:0]            tick_ff;
   logic                  int_done;
   logic                  push_v;
   logic                  buf_in_rdy;
   logic                  buf_out_v;
   logic                  pop_rdy;
   logic                  ext_f8;
   logic [7:0]            buf_data;
   logic [7:0]            rd_ff;
   logic [3:0]            rd_cnt_ff;
   logic                  rd_int_ff;
   logic                  track_ff;
   logic                  conv_ff;
   adcs_pkg::adcs_mux_t   mux_ff;
   logic                  ref_sel_ff;
   logic                  chip_on_ff;
   logic                  ref_on_ff;
   logic                  prev_ref_int_ff;
   logic                  nxt_chip_on;
   logic                  nxt_ref_on;
   logic [12:0]           wake_ff;
   logic                  dout_ff;
   logic                  dout_oe_ff;
   logic [13:0]           iconv_cyc_ff;

   // Reset release through two flops
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_s = rst_sync_ff[1];

   // Pin synchronisers: bit 2 select, bit 1 serial clock, bit 0 data
   for (genvar i = 0; i < 3; i++)
   begin : g_sync
      always_ff @(posedge clock_in or negedge rst_s)
      begin
         if (!rst_s)
         begin
            pin_s1_ff[i] <= adcs_pkg::SYNC_RST[i];
            pin_s2_ff[i] <= adcs_pkg::SYNC_RST[i];
         end
         else
         begin
            pin_s1_ff[i] <= (i == 2) ? cs_n_in : (i == 1) ? sclk_in : din_in;
            pin_s2_ff[i] <= pin_s1_ff[i];
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         sclk_d_ff <= 1'b0;
         cs_d_ff   <= 1'b1;
      end
      else
      begin
         sclk_d_ff <= pin_s2_ff[1];
         cs_d_ff   <= pin_s2_ff[2];
      end
   end

   assign cs_s    = pin_s2_ff[2];
   assign din_s   = pin_s2_ff[0];
   // Edges count only with select low
   assign rise    = pin_s2_ff[1] & ~sclk_d_ff & ~cs_s;
   assign fall    = ~pin_s2_ff[1] & sclk_d_ff & ~cs_s;
   assign cs_rise = cs_s & ~cs_d_ff;

   assign fr_rise = (state_ff == adcs_pkg::ST_FRAME) & rise;
   assign fr_fall = (state_ff == adcs_pkg::ST_FRAME) & fall;
   assign ext_f8  = fr_fall & ext_ff & (fcnt_ff == adcs_pkg::EDGE_CTRL);

   // Idle accepts a start; wait for bit 4 of an internal result
   // Overlap after bit 5 shown; ten clocks per conversion
   assign allow_start =
      ((state_ff == adcs_pkg::ST_IDLE) &
       ~(rd_int_ff & (rd_cnt_ff < adcs_pkg::RD_OVL_INT))) |
      ((state_ff == adcs_pkg::ST_FRAME) & ext_ff &
       (fcnt_ff >= adcs_pkg::EDGE_OVL_EXT) & (rd_cnt_ff >= adcs_pkg::RD_OVL_EXT));
   // Only a high bit starts; leading zeros ignored
   assign start_ev = rise & din_s & allow_start;
   // Select toggle abandons a frame still in progress
   assign abort_ev = cs_rise & (state_ff == adcs_pkg::ST_FRAME);
   assign ext_end  = fr_fall & ext_ff & (fcnt_ff == adcs_pkg::EDGE_EXT_DONE);
   assign int_done = (state_ff == adcs_pkg::ST_ICONV) &
                     (tick_ff == 4'(adcs_pkg::CONV_TICKS)) & buf_in_rdy;
   assign conv_end = ext_end | int_done |
                     (start_ev & (state_ff == adcs_pkg::ST_FRAME));

   // Frame sequencer
   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         state_ff <= adcs_pkg::ST_IDLE;
         fcnt_ff  <= 4'h0;
         shift_ff <= 8'h00;
         ext_ff   <= 1'b0;
         ctrl_ff  <= adcs_pkg::CTRL_RST;
      end
      else if (start_ev)
      begin
         state_ff <= adcs_pkg::ST_FRAME;
         fcnt_ff  <= 4'h1;
         shift_ff <= 8'h01;
      end
      else
      begin
         case (state_ff)
            adcs_pkg::ST_FRAME:
            begin
               if (abort_ev || ext_end)
                  state_ff <= adcs_pkg::ST_IDLE;
               // Internal conversion begins at fall 8
               else if (fr_fall && !ext_ff && fcnt_ff == adcs_pkg::EDGE_CTRL)
                  state_ff <= adcs_pkg::ST_ICONV;
               else if (rise && fcnt_ff != adcs_pkg::EDGE_EXT_DONE)
               begin
                  fcnt_ff <= fcnt_ff + 4'h1;
                  if (fcnt_ff < adcs_pkg::EDGE_CTRL)
                     shift_ff <= {shift_ff[6:0], din_s};
                  // Clock select is the fifth bit
                  if (fcnt_ff == adcs_pkg::EDGE_SEL)
                     ext_ff <= din_s;
                  // Repeated all-ones byte latched like any other
                  if (fcnt_ff == adcs_pkg::EDGE_CTRL - 4'h1)
                     ctrl_ff <= {shift_ff[6:0], din_s};
               end
            end
            adcs_pkg::ST_ICONV:
            begin
               // Internal conversion ignores the select pin
               if (int_done)
                  state_ff <= adcs_pkg::ST_IDLE;
            end
            default:
               state_ff <= adcs_pkg::ST_IDLE;
         endcase
      end
   end

   // Internal oscillator ticks and conversion step count
   assign osc_tick = (osc_ff == 10'(adcs_pkg::OSC_DIV - 1));
   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         osc_ff  <= 10'h000;
         tick_ff <= 4'h0;
      end
      else if (state_ff != adcs_pkg::ST_ICONV)
      begin
         osc_ff  <= 10'h000;
         tick_ff <= 4'h0;
      end
      else
      begin
         osc_ff <= osc_tick ? 10'h000 : osc_ff + 10'h001;
         if (osc_tick && tick_ff != 4'(adcs_pkg::CONV_TICKS))
            tick_ff <= tick_ff + 4'h1;
      end
   end

   // External top bit decided on rise 7
   assign push_v  = (fr_rise & ext_ff & (fcnt_ff == adcs_pkg::EDGE_EXT_MSB - 4'h1)) |
                    int_done;
   assign pop_rdy = ext_f8 | ((rd_cnt_ff == adcs_pkg::RD_IDLE) &
                    ~((state_ff == adcs_pkg::ST_FRAME) & ext_ff));

   adcs_pair_fifo #(.WIDTH(8), .DEPTH(2)) u_result_buf (
      .clock_in      (clock_in),
      .rst_n_in      (rst_s),
      .in_valid_in   (push_v),
      .in_ready_out  (buf_in_rdy),
      .in_data_in    (sample_code_in),
      .out_valid_out (buf_out_v),
      .out_ready_in  (pop_rdy),
      .out_data_out  (buf_data)
   );

   // Readout shifter
   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         rd_ff     <= 8'h00;
         rd_cnt_ff <= adcs_pkg::RD_IDLE;
         rd_int_ff <= 1'b0;
      end
      // Internal result waits with its top bit shown
      else if (pop_rdy && buf_out_v)
      begin
         rd_ff     <= buf_data;
         rd_cnt_ff <= adcs_pkg::RD_FIRST;
         rd_int_ff <= ~ext_f8;
      end
      // Select high ends an external readout
      else if (cs_rise && !rd_int_ff)
      begin
         rd_ff     <= 8'h00;
         rd_cnt_ff <= adcs_pkg::RD_IDLE;
      end
      else if (fall && rd_cnt_ff != adcs_pkg::RD_IDLE)
      begin
         rd_ff     <= {rd_ff[6:0], 1'b0};
         rd_cnt_ff <= rd_cnt_ff + 4'h1;
         if (rd_cnt_ff == adcs_pkg::RD_IDLE - 4'h1)
            rd_int_ff <= 1'b0;
      end
   end

   // Track from fall 4, two or four clocks, then convert
   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         track_ff <= 1'b0;
         conv_ff  <= 1'b0;
      end
      else if (abort_ev || start_ev || conv_end)
      begin
         track_ff <= 1'b0;
         conv_ff  <= 1'b0;
      end
      else if (fr_fall && fcnt_ff == adcs_pkg::EDGE_TRACK)
         track_ff <= 1'b1;
      // External conversion starts at fall 6
      else if (fr_fall && ext_ff && fcnt_ff == adcs_pkg::EDGE_EXT_CONV)
      begin
         track_ff <= 1'b0;
         conv_ff  <= 1'b1;
      end
      // Internal acquisition ends at fall 8
      else if (fr_fall && !ext_ff && fcnt_ff == adcs_pkg::EDGE_CTRL)
      begin
         track_ff <= 1'b0;
         conv_ff  <= 1'b1;
      end
   end

   // Input select decode at rise 4
   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         mux_ff     <= '0;
         ref_sel_ff <= 1'b0;
      end
      else if (fr_rise && fcnt_ff == adcs_pkg::EDGE_SEL - 4'h1)
      begin
         mux_ff.bipolar <= ~shift_ff[1] & (shift_ff[1:0] != 2'h0 | din_s);
         mux_ff.pos_sel <= ({shift_ff[1:0], din_s} == 3'h0) ? adcs_pkg::POS_HALF :
                           din_s ? adcs_pkg::POS_A : adcs_pkg::POS_B;
         if (shift_ff[1:0] == 2'h0)
            mux_ff.neg_sel <= din_s ? adcs_pkg::NEG_B : adcs_pkg::NEG_GND;
         else
            mux_ff.neg_sel <= (shift_ff[1:0] == 2'h3 || shift_ff[1:0] == 2'h1) ?
                              adcs_pkg::NEG_COM : adcs_pkg::NEG_GND;
      end
      else if (fr_rise && fcnt_ff == adcs_pkg::EDGE_CLKSEL)
         ref_sel_ff <= din_s;
   end

   // Power bits applied at conversion end; start wakes
   always_comb
   begin
      nxt_chip_on = chip_on_ff;
      nxt_ref_on  = ref_on_ff;
      if (conv_end)
      begin
         nxt_chip_on = ctrl_ff.chip_power_on;
         nxt_ref_on  = ctrl_ff.reference_power_on & ctrl_ff.reference_source_select;
      end
      if (start_ev)
      begin
         nxt_chip_on = 1'b1;
         if (conv_end ? ctrl_ff.reference_source_select : prev_ref_int_ff)
            nxt_ref_on = 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         chip_on_ff      <= adcs_pkg::CHIP_ON_RST;
         ref_on_ff       <= adcs_pkg::REF_ON_RST;
         prev_ref_int_ff <= 1'b0;
         wake_ff         <= 13'h0000;
      end
      else
      begin
         chip_on_ff <= nxt_chip_on;
         ref_on_ff  <= nxt_ref_on;
         if (conv_end)
            prev_ref_int_ff <= ctrl_ff.reference_source_select;
         if (start_ev && !chip_on_ff)
            wake_ff <= 13'(WAKE_CYCLES);
         else if (wake_ff != 13'h0000)
            wake_ff <= wake_ff - 13'h0001;
      end
   end

   // Output drive; on as soon as select falls, showing the top bit of rd_ff
   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
      begin
         dout_ff    <= 1'b0;
         dout_oe_ff <= 1'b0;
      end
      else
      begin
         dout_ff    <= rd_ff[7] & ~cs_s;
         dout_oe_ff <= ~cs_s;
      end
   end

   assign dout_out                    = dout_ff;
   assign dout_oe_out                 = dout_oe_ff;
   assign track_out                   = track_ff;
   assign converting_out              = conv_ff;
   assign mux_out                     = mux_ff;
   assign reference_source_select_out = ref_sel_ff;
   assign reference_power_on_out      = ref_on_ff;
   assign chip_power_on_out           = chip_on_ff;
   assign waking_out                  = (wake_ff != 13'h0000);

   // Cycles spent converting, paused while the buffer is full
   always_ff @(posedge clock_in or negedge rst_s)
   begin
      if (!rst_s)
         iconv_cyc_ff <= 14'h0000;
      else if (state_ff != adcs_pkg::ST_ICONV)
         iconv_cyc_ff <= 14'h0000;
      else if (buf_in_rdy && iconv_cyc_ff != 14'h3fff)
         iconv_cyc_ff <= iconv_cyc_ff + 14'h0001;
   end

   default clocking dc @(posedge clock_in); endclocking
   default disable iff (!rst_s);

   a_cs_high_tristate: assert property (cs_s |=> !dout_oe_out)
      else $error("Output driven with select high");
   a_ext_acq_two: assert property (fr_fall && ext_ff && fcnt_ff == 4'h4 && !cs_rise
      |=> track_out)
      else $error("Track not entered at fall 4");
   a_ext_conv_six: assert property (fr_fall && ext_ff && fcnt_ff == 4'h6 && !abort_ev
      |=> !track_out && converting_out)
      else $error("External conversion not started at fall 6");
   a_int_conv_eight: assert property (fr_fall && !ext_ff && fcnt_ff == 4'h8
      |=> state_ff == adcs_pkg::ST_ICONV)
      else $error("Internal conversion not started at fall 8");
   a_zero_fill: assert property (rd_cnt_ff == 4'h9 && !cs_s |=> !dout_out)
      else $error("Nonzero output after last bit");
   a_no_cs_start: assert property (state_ff == adcs_pkg::ST_IDLE && !rise
      |=> state_ff == adcs_pkg::ST_IDLE)
      else $error("Frame began without a start bit");
   a_power_defer: assert property ($fell(chip_on_ff) |-> $past(conv_end))
      else $error("Power-down before conversion end");
   a_no_early_ovl: assert property (fr_rise && ext_ff && fcnt_ff < 4'ha && fcnt_ff != 4'hf
      |=> fcnt_ff == $past(fcnt_ff) + 4'h1)
      else $error("Frame restarted before bit 5 shown");
   a_ext_top_bit: assert property (ext_f8 && buf_out_v
      |=> rd_cnt_ff == 4'h1 ##1 dout_out == rd_ff[7] || cs_s)
      else $error("Top bit not shown at fall 8");
   a_int_bound: assert property (iconv_cyc_ff <= 14'(adcs_pkg::CONV_MAX_CYC))
      else $error("Internal conversion too long");

endmodule // adcs_sequencer
